// >>> design/psr_top.sv
// AXI4-Lite slave holding the read-only PLL status register and its two control bits.
`timescale 1ns/1ps
`include "psr_defines.svh"

// Operation
// - Calibration-done bit reads 1 once VCO calibration has completed.
// - Calibration-done sits at status bit 6 and reads 0 before calibration finishes.
// - Bit 5 shows the live holdover state, not the holdover enable.
// - Bit 4 is 1 when secondary reference feeds the PLL, else 0.
// - Bit 3 is 1 when VCO frequency is above its threshold.
// - Bit 2 shows secondary reference above threshold; threshold chosen by 0x01A bit 6.
// - Bit 1 is 1 when primary reference frequency exceeds the threshold.
// - Bit 0 presents digital lock detect: 1 locked, 0 not locked.
// - Register 0x01D bit 4 set disables status readback; clear enables it.
module psr_top #(
   parameter int ADDR_WIDTH = 12
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic [ADDR_WIDTH-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // Write data channel
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response channel
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read address channel
   input wire logic [ADDR_WIDTH-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // Read data channel
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // PLL side flags and threshold control
   input wire psr_pkg::psr_flags_type pll_flags,
   output logic freq_thresh_select
);

   psr_pkg::psr_state_type st;
   psr_pkg::psr_state_type next_st;
   logic [6:0] flags_sync;

   initial begin
      if (ADDR_WIDTH < 7 || ADDR_WIDTH > 12) begin
         $error("psr_top needs ADDR_WIDTH between 7 and 12");
      end
   end

   // Byte address to word index; bits above the index width alias.
   function automatic logic [9:0] psr_index(input logic [ADDR_WIDTH-1:0] addr);
      psr_index = 10'(addr >> 2);
   endfunction

   // The flags come from analog and reference-clock domains.
   psr_sync #(
      .WIDTH(7)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(pll_flags),
      .sync_out(flags_sync)
   );

   always_comb begin
      next_st = st;
      // Status follows the live flags only; no write path reaches it.
      next_st.status = psr_pkg::psr_status_type'({1'h0, flags_sync});
      if (awvalid && st.awready) begin
         next_st.aw_held = 1'h1;
         next_st.aw_index = psr_index(awaddr);
      end
      if (wvalid && st.wready) begin
         next_st.w_held = 1'h1;
         next_st.w_low = wdata[7:0];
         next_st.w_strb0 = wstrb[0];
      end
      if (bready && st.bvalid) begin
         next_st.bvalid = 1'h0;
      end
      // Commit one cycle after both halves are held, so either arrival order works.
      if (st.aw_held && st.w_held && !st.bvalid) begin
         next_st.aw_held = 1'h0;
         next_st.w_held = 1'h0;
         next_st.bvalid = 1'h1;
         next_st.bresp = `PSR_RESP_OKAY;
         if (st.aw_index == `PSR_IDX_THRESH) begin
            if (st.w_strb0) begin
               next_st.thresh_select = st.w_low[`PSR_BIT_THRESH_SEL];
            end
         end else if (st.aw_index == `PSR_IDX_PLLCTRL) begin
            if (st.w_strb0) begin
               next_st.readback_disable = st.w_low[`PSR_BIT_RB_DISABLE];
            end
         end else if (st.aw_index == `PSR_IDX_STATUS) begin
            // Accepted with OKAY and dropped, so software sees no fault.
            next_st.bresp = `PSR_RESP_OKAY;
         end else begin
            next_st.bresp = `PSR_RESP_SLVERR;
         end
      end
      next_st.awready = !next_st.aw_held && !next_st.bvalid;
      next_st.wready = !next_st.w_held && !next_st.bvalid;
      if (rready && st.rvalid) begin
         next_st.rvalid = 1'h0;
      end
      // The answer is registered, so rdata stands unchanged until rready takes it.
      if (arvalid && st.arready) begin
         next_st.rvalid = 1'h1;
         next_st.rresp = `PSR_RESP_OKAY;
         next_st.rdata = 32'h00000000;
         if (psr_index(araddr) == `PSR_IDX_STATUS) begin
            // A disabled readback answers OKAY with zeros rather than an error.
            if (!st.readback_disable) begin
               next_st.rdata = {24'h000000, st.status};
            end
         end else if (psr_index(araddr) == `PSR_IDX_THRESH) begin
            next_st.rdata[`PSR_BIT_THRESH_SEL] = st.thresh_select;
         end else if (psr_index(araddr) == `PSR_IDX_PLLCTRL) begin
            next_st.rdata[`PSR_BIT_RB_DISABLE] = st.readback_disable;
         end else begin
            next_st.rresp = `PSR_RESP_SLVERR;
         end
      end
      next_st.arready = !next_st.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Control bits return to their defaults; the flags read zero until resynchronised.
         st <= '0;
         st.thresh_select <= `PSR_RST_THRESH_SEL;
         st.readback_disable <= `PSR_RST_RB_DISABLE;
      end else begin
         st <= next_st;
      end
   end

   assign awready = st.awready;
   assign wready = st.wready;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = st.arready;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign freq_thresh_select = st.thresh_select;

   default clocking psr_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Read data is a snapshot of the status register, one edge behind the synchroniser.
   sequence s_status_read;
      arvalid && arready && psr_index(araddr) == `PSR_IDX_STATUS && !st.readback_disable;
   endsequence

   sequence s_status_off;
      arvalid && arready && psr_index(araddr) == `PSR_IDX_STATUS && st.readback_disable;
   endsequence

   sequence s_status_write;
      st.aw_held && st.w_held && !st.bvalid && st.aw_index == `PSR_IDX_STATUS;
   endsequence

   sequence s_thresh_write;
      st.aw_held && st.w_held && !st.bvalid && st.aw_index == `PSR_IDX_THRESH && st.w_strb0;
   endsequence

   sequence s_ctrl_write;
      st.aw_held && st.w_held && !st.bvalid && st.aw_index == `PSR_IDX_PLLCTRL && st.w_strb0;
   endsequence

   // Each flag bit must match the synchroniser output two edges before the data is seen.
   a_cal_done_one: assert property (s_status_read ##0 $past(flags_sync[6]) |=> rdata[6])
      else $error("calibration done not read as one");
   a_cal_done_zero: assert property (s_status_read ##0 !$past(flags_sync[6])
         |=> !rdata[6])
      else $error("calibration done read as one too early");
   a_holdover_live: assert property (s_status_read
         |=> rdata[5] == $past(flags_sync[5], 2))
      else $error("holdover bit does not follow live state");
   a_ref_selected: assert property (s_status_read |=> rdata[4] == $past(flags_sync[4], 2))
      else $error("reference select bit wrong");
   a_vco_above: assert property (s_status_read |=> rdata[3] == $past(flags_sync[3], 2))
      else $error("VCO threshold bit wrong");
   a_sec_above: assert property (s_status_read
         |=> rvalid && rdata[2] == $past(flags_sync[2], 2))
      else $error("secondary threshold bit wrong");
   a_pri_above: assert property (s_status_read |=> rdata[1] == $past(flags_sync[1], 2))
      else $error("primary threshold bit wrong");
   a_lock_detect: assert property (s_status_read
         |=> rdata[0] == $past(flags_sync[0], 2) && !rdata[7])
      else $error("lock detect bit wrong");
   a_readback_off: assert property (s_status_off
         |=> rvalid && rdata == 32'h00000000 && rresp == `PSR_RESP_OKAY)
      else $error("status readable while disabled");
   a_status_ro: assert property (s_status_write |=> bvalid && bresp == `PSR_RESP_OKAY
         && $stable(st.thresh_select) && $stable(st.readback_disable)
         ##0 st.status == {1'h0, $past(flags_sync)})
      else $error("write to status had an effect");
   a_status_live: assert property (st.status == {1'h0, $past(flags_sync)})
      else $error("status register does not follow the synchronised flags");

   // Outside reset, the control bits change only through a committed write with the low strobe set.
   a_thresh_write: assert property (s_thresh_write
         |=> freq_thresh_select == $past(st.w_low[`PSR_BIT_THRESH_SEL]))
      else $error("threshold select not taken from the write");
   a_thresh_keep: assert property ($changed(freq_thresh_select)
         |-> $past(st.aw_held && st.w_held && !st.bvalid && st.aw_index == `PSR_IDX_THRESH))
      else $error("threshold select changed without a write");
   a_rb_write: assert property (s_ctrl_write
         |=> st.readback_disable == $past(st.w_low[`PSR_BIT_RB_DISABLE]))
      else $error("readback disable not taken from the write");

endmodule

// >>> design/psr_defines.svh
// Register indices, field positions, responses and reset values of the PLL status block.
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH

`define PSR_IDX_WIDTH 10
`define PSR_IDX_THRESH 10'h01A
`define PSR_IDX_PLLCTRL 10'h01D
`define PSR_IDX_STATUS 10'h01F

`define PSR_BIT_THRESH_SEL 6
`define PSR_BIT_RB_DISABLE 4

`define PSR_BIT_CAL_DONE 6
`define PSR_BIT_HOLDOVER 5
`define PSR_BIT_SEC_SELECTED 4
`define PSR_BIT_VCO_ABOVE 3
`define PSR_BIT_SEC_ABOVE 2
`define PSR_BIT_PRI_ABOVE 1
`define PSR_BIT_LOCKED 0

`define PSR_RESP_OKAY 2'h0
`define PSR_RESP_SLVERR 2'h2

`define PSR_RST_THRESH_SEL 1'h0
`define PSR_RST_RB_DISABLE 1'h0

`define PSR_SYNC_STAGES 2

`endif

// >>> design/psr_pkg.sv
// Types shared by the PLL status readback block.
package psr_pkg;

   // Raw flags from the PLL, holdover controller, monitors and lock detector.
   typedef struct packed {
      logic cal_done;
      logic holdover_active;
      logic secondary_selected;
      logic vco_above;
      logic secondary_above;
      logic primary_above;
      logic locked;
   } psr_flags_type;

   // Status register image, bit 7 reserved.
   typedef struct packed {
      logic reserved;
      psr_flags_type flags;
   } psr_status_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_held;
      logic [9:0] aw_index;
      logic w_held;
      logic [7:0] w_low;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic thresh_select;
      logic readback_disable;
      psr_status_type status;
   } psr_state_type;

endpackage

// >>> design/psr_sync.sv
// Two-stage synchroniser bank for flags arriving from other clock domains.
`timescale 1ns/1ps
module psr_sync #(
   parameter int WIDTH = 7
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Flags
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } psr_sync_state_type;

   psr_sync_state_type st;
   psr_sync_state_type next_st;

   initial begin
      if (WIDTH < 1) begin
         $error("psr_sync needs WIDTH of at least one");
      end
   end

   // The meta stage feeds only the stable stage, never any logic.
   always_comb begin
      next_st.meta = async_in;
      next_st.stable = st.meta;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.stable;

endmodule

// >>> dv/tb.sv
// Self-checking bench for the PLL status readback block over AXI4-Lite.
`timescale 1ns/1ps
`include "psr_defines.svh"
`define TB_CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic awready, wready, bvalid, arready, rvalid, freq_thresh_select;
   psr_pkg::psr_flags_type pll_flags;
   int errors = 0;
   int cmp_count = 0;
   localparam logic [11:0] A_TH = {`PSR_IDX_THRESH, 2'h0};
   localparam logic [11:0] A_CT = {`PSR_IDX_PLLCTRL, 2'h0};
   localparam logic [11:0] A_ST = {`PSR_IDX_STATUS, 2'h0};
   // One row per flag, then all set and none set; bit 7 must read 0.
   localparam logic [6:0] FL [9] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01,
      7'h7F, 7'h00};
   localparam logic [31:0] EX [9] = '{32'h40, 32'h20, 32'h10, 32'h08, 32'h04, 32'h02, 32'h01,
      32'h7F, 32'h00};
   psr_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .pll_flags(pll_flags),
      .freq_thresh_select(freq_thresh_select));
   initial begin
      aclk = 1'h0;
      forever #2 aclk = ~aclk;
   end
   task end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Valid drops at the edge that takes it; ready for the answer is held until it comes.
   task wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'h0;
   endtask
   task rd(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask
   // Flags cross two sync stages and the status register, so four edges is enough.
   task setf(input logic [6:0] f);
      @(posedge aclk);
      pll_flags <= f;
      repeat (4) @(posedge aclk);
   endtask
   initial begin
      repeat (5000) @(posedge aclk);
      errors++;
      end_sim();
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0;
      wstrb = 4'hF;
      pll_flags = 7'h00;
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      rd(A_ST);
      `TB_CHK(d, 32'h00)
      rd(A_CT);
      `TB_CHK(d, 32'h00)
      $display("reset test done");
      for (int i = 0; i < 9; i++) begin
         setf(FL[i]);
         rd(A_ST);
         `TB_CHK(d, EX[i])
         `TB_CHK(r, `PSR_RESP_OKAY)
      end
      $display("flag table test done");
      wr(A_TH, 32'hFF, 4'hF);
      rd(A_TH);
      `TB_CHK(d, 32'h40)
      `TB_CHK(freq_thresh_select, 1'h1)
      wr(A_TH, 32'h00, 4'hE);
      `TB_CHK(freq_thresh_select, 1'h1)
      wr(A_TH, 32'h00, 4'hF);
      `TB_CHK(freq_thresh_select, 1'h0)
      $display("threshold test done");
      setf(7'h7F);
      wr(A_ST, 32'h00, 4'hF);
      `TB_CHK(r, `PSR_RESP_OKAY)
      rd(A_ST);
      `TB_CHK(d, 32'h7F)
      $display("status write test done");
      wr(A_CT, 32'hFF, 4'hF);
      rd(A_CT);
      `TB_CHK(d, 32'h10)
      rd(A_ST);
      `TB_CHK(d, 32'h00)
      `TB_CHK(r, `PSR_RESP_OKAY)
      wr(A_CT, 32'h00, 4'hF);
      rd(A_ST);
      `TB_CHK(d, 32'h7F)
      $display("readback disable test done");
      // Mid-run reset with both control bits set: they must come back cleared.
      wr(A_TH, 32'hFF, 4'hF);
      wr(A_CT, 32'hFF, 4'hF);
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      `TB_CHK(freq_thresh_select, 1'h0)
      rd(A_CT);
      `TB_CHK(d, 32'h00)
      rd(A_TH);
      `TB_CHK(d, 32'h00)
      rd(A_ST);
      `TB_CHK(d, 32'h7F)
      $display("mid-run reset test done");
      wr(12'h000, 32'hFF, 4'hF);
      `TB_CHK(r, `PSR_RESP_SLVERR)
      rd(12'h000);
      `TB_CHK(r, `PSR_RESP_SLVERR)
      `TB_CHK(d, 32'h00)
      $display("unmapped test done");
      end_sim();
   end
endmodule
